// *** design/gsm_pkg.sv ***
/*
 * gsm_pkg: widths, operation codes, states and conversion sizes for the
 * Gray / digit shuffle / table move execution unit.
 * Assumes nothing of its surroundings; shared by the buffer and the execution unit.
 */
package gsm_pkg;
    localparam int GSM_ACC_W = 32;
    localparam int GSM_WORD_W = 16;
    localparam int GSM_ADDR_W = 17;
    localparam int GSM_CNT_W = 16;
    localparam int GSM_MOVE_CNT_W = 12;
    localparam int GSM_GRAY_W = 16;
    localparam int GSM_BIN_W = 10;
    localparam int GSM_BCD_W = 16;
    localparam int GSM_BCD_KEEP = 10;
    localparam int GSM_DIGIT_W = 4;
    localparam int GSM_DIGITS = 8;
    localparam int GSM_BUF_DEPTH = 2;
    localparam int GSM_ENTRY_W = GSM_ADDR_W + GSM_WORD_W;

    // memory spaces seen on the read and write ports
    localparam logic GSM_SPACE_WORD = 1'h0;
    localparam logic GSM_SPACE_LABEL = 1'h1;

    typedef enum logic [2:0] {
        GSM_OP_GRAY = 3'h0,
        GSM_OP_SHUFFLE = 3'h1,
        GSM_OP_TABLE_MOVE = 3'h2,
        GSM_OP_LABEL_TO_WORD = 3'h3,
        GSM_OP_WORD_TO_LABEL = 3'h4
    } gsm_op_t;

    typedef enum logic [1:0] {
        GSM_ST_IDLE = 2'h1,
        GSM_ST_RUN = 2'h2
    } gsm_state_t;
endpackage

// *** design/gsm_stream_if.sv ***
/*
 * gsm_stream_if: valid/ready word stream between the execution unit and
 * its two-entry buffer. Assumes both ends share one clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface gsm_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** design/gsm_pair_buf.sv ***
/*
 * gsm_pair_buf: two-entry first-in first-out buffer with valid/ready on
 * both sides. Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module gsm_pair_buf #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // streams
    gsm_stream_if.snk in_s,
    gsm_stream_if.src out_s
);
    import gsm_pkg::*;

    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic rd_ptr;
        logic wr_ptr;
        logic [1:0] count;
    } gsm_buf_q_t;

    gsm_buf_q_t q;
    gsm_buf_q_t next_q;
    logic push;
    logic pop;

    assign in_s.ready = (q.count < 2'(GSM_BUF_DEPTH));
    assign out_s.valid = (q.count != 2'h0);
    assign out_s.data = q.mem[q.rd_ptr];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    always_comb begin
        next_q = q;
        if (push) begin
            next_q.mem[q.wr_ptr] = in_s.data;
            next_q.wr_ptr = ~q.wr_ptr;
        end
        if (pop) begin
            next_q.rd_ptr = ~q.rd_ptr;
        end
        if (push && !pop) begin
            next_q.count = q.count + 2'h1;
        end else if (pop && !push) begin
            next_q.count = q.count - 2'h1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
endmodule
`default_nettype wire

// *** design/gsm_exec_unit.sv ***
/*
 * gsm_exec_unit: accumulator execution unit for Gray to BCD conversion,
 * digit shuffling, word table moves and label memory copies.
 * Assumes the host core supplies accumulator and stack levels with each
 * command on the same clock, and that both memories answer reads in order.
 */
`timescale 1ns/1ps
`default_nettype none
module gsm_exec_unit (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // command from the host core
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire gsm_pkg::gsm_op_t cmd_op_i,
    input wire logic [gsm_pkg::GSM_ACC_W-1:0] acc_i,
    input wire logic [gsm_pkg::GSM_ACC_W-1:0] stack1_i,
    input wire logic [gsm_pkg::GSM_ACC_W-1:0] stack2_i,
    input wire logic [gsm_pkg::GSM_ADDR_W-1:0] operand_i,
    // result
    output logic done_o,
    output logic [gsm_pkg::GSM_ACC_W-1:0] acc_o,
    // source read port
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic rd_space_o,
    output logic [gsm_pkg::GSM_ADDR_W-1:0] rd_addr_o,
    input wire logic rd_data_valid_i,
    input wire logic [gsm_pkg::GSM_WORD_W-1:0] rd_data_i,
    // destination write port
    output logic wr_valid_o,
    input wire logic wr_ready_i,
    output logic wr_space_o,
    output logic [gsm_pkg::GSM_ADDR_W-1:0] wr_addr_o,
    output logic [gsm_pkg::GSM_WORD_W-1:0] wr_data_o
);
    import gsm_pkg::*;

    typedef struct packed {
        gsm_state_t state;
        logic [GSM_ACC_W-1:0] acc;
        logic done;
        logic [GSM_ADDR_W-1:0] rd_addr;
        logic [GSM_ADDR_W-1:0] wr_addr;
        logic [GSM_CNT_W-1:0] left_rd;
        logic [GSM_CNT_W-1:0] left_wr;
        logic src_space;
        logic dst_space;
        logic pending;
    } gsm_q_t;

    localparam gsm_q_t Q_RESET = '{state: GSM_ST_IDLE, default: '0};

    gsm_q_t q;
    gsm_q_t next_q;
    logic rd_fire;
    logic push;
    logic pop;
    logic [GSM_BCD_W-1:0] gray_bcd;

    gsm_stream_if #(.W(GSM_ENTRY_W)) fill_s ();
    gsm_stream_if #(.W(GSM_ENTRY_W)) drain_s ();

    gsm_pair_buf #(.W(GSM_ENTRY_W)) u_buf (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .in_s(fill_s.snk),
        .out_s(drain_s.src)
    );

    function automatic logic [GSM_BCD_W-1:0] gray_to_bcd(
        input logic [GSM_GRAY_W-1:0] g
    );
        logic [GSM_GRAY_W-1:0] b;
        logic [GSM_BCD_W-1:0] bcd;
        b = '0;
        bcd = '0;
        b[GSM_GRAY_W-1] = g[GSM_GRAY_W-1];
        for (int i = GSM_GRAY_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        // binary to BCD by shift and add-three over the encoder range
        for (int i = GSM_BIN_W - 1; i >= 0; i--) begin
            for (int d = 0; d < GSM_BCD_W / GSM_DIGIT_W; d++) begin
                if (bcd[d*GSM_DIGIT_W +: GSM_DIGIT_W] > 4'h4) begin
                    bcd[d*GSM_DIGIT_W +: GSM_DIGIT_W] =
                        bcd[d*GSM_DIGIT_W +: GSM_DIGIT_W] + 4'h3;
                end
            end
            bcd = {bcd[GSM_BCD_W-2:0], b[i]};
        end
        return bcd;
    endfunction

    function automatic logic [GSM_ACC_W-1:0] shuffle(
        input logic [GSM_ACC_W-1:0] src,
        input logic [GSM_ACC_W-1:0] order
    );
        logic [GSM_ACC_W-1:0] res;
        logic [GSM_DIGIT_W-1:0] sel;
        res = '0;
        sel = '0;
        // ascending walk lets the more significant duplicate overwrite
        for (int i = 0; i < GSM_DIGITS; i++) begin
            sel = order[i*GSM_DIGIT_W +: GSM_DIGIT_W];
            if (sel >= 4'h1 && sel <= 4'h8) begin
                res[(32'(sel) - 1) * GSM_DIGIT_W +: GSM_DIGIT_W] =
                    src[i*GSM_DIGIT_W +: GSM_DIGIT_W];
            end
        end
        return res;
    endfunction

    // a function result cannot be sliced directly, so it is named first
    assign gray_bcd = gray_to_bcd(acc_i[GSM_GRAY_W-1:0]);

    // one read in flight at most, issued only while the buffer has room,
    // so a returning word can always be pushed even if writes stall
    assign rd_valid_o = (q.state == GSM_ST_RUN) && (q.left_rd != '0) &&
                        !q.pending && fill_s.ready;
    assign rd_fire = rd_valid_o && rd_ready_i;
    assign rd_space_o = q.src_space;
    assign rd_addr_o = q.rd_addr;

    assign fill_s.valid = q.pending && rd_data_valid_i;
    assign fill_s.data = {q.wr_addr, rd_data_i};
    assign push = fill_s.valid && fill_s.ready;

    assign drain_s.ready = wr_ready_i;
    assign wr_valid_o = drain_s.valid;
    assign wr_addr_o = drain_s.data[GSM_ENTRY_W-1:GSM_WORD_W];
    assign wr_data_o = drain_s.data[GSM_WORD_W-1:0];
    assign wr_space_o = q.dst_space;
    assign pop = drain_s.valid && wr_ready_i;

    assign cmd_ready_o = (q.state == GSM_ST_IDLE);
    assign done_o = q.done;
    assign acc_o = q.acc;

    always_comb begin
        next_q = q;
        next_q.done = 1'b0;
        unique case (q.state)
            GSM_ST_IDLE: begin
                if (cmd_valid_i) begin
                    case (cmd_op_i)
                        GSM_OP_GRAY: begin
                            next_q.acc = {{(GSM_ACC_W - GSM_BCD_KEEP){1'b0}},
                                gray_bcd[GSM_BCD_KEEP-1:0]};
                            next_q.done = 1'b1;
                        end
                        GSM_OP_SHUFFLE: begin
                            next_q.acc = shuffle(stack1_i, acc_i);
                            next_q.done = 1'b1;
                        end
                        GSM_OP_TABLE_MOVE: begin
                            next_q.rd_addr = acc_i[GSM_ADDR_W-1:0];
                            next_q.wr_addr = operand_i;
                            next_q.left_rd = GSM_CNT_W'(
                                stack1_i[GSM_MOVE_CNT_W-1:0]);
                            next_q.left_wr = GSM_CNT_W'(
                                stack1_i[GSM_MOVE_CNT_W-1:0]);
                            next_q.src_space = GSM_SPACE_WORD;
                            next_q.dst_space = GSM_SPACE_WORD;
                            next_q.state = GSM_ST_RUN;
                        end
                        GSM_OP_LABEL_TO_WORD,
                        GSM_OP_WORD_TO_LABEL: begin
                            // offset applies to both ends, unchecked
                            next_q.rd_addr = acc_i[GSM_ADDR_W-1:0] +
                                stack1_i[GSM_ADDR_W-1:0];
                            next_q.wr_addr = operand_i +
                                stack1_i[GSM_ADDR_W-1:0];
                            next_q.left_rd = stack2_i[GSM_CNT_W-1:0];
                            next_q.left_wr = stack2_i[GSM_CNT_W-1:0];
                            next_q.src_space =
                                (cmd_op_i == GSM_OP_LABEL_TO_WORD) ?
                                GSM_SPACE_LABEL : GSM_SPACE_WORD;
                            next_q.dst_space =
                                (cmd_op_i == GSM_OP_LABEL_TO_WORD) ?
                                GSM_SPACE_WORD : GSM_SPACE_LABEL;
                            next_q.state = GSM_ST_RUN;
                        end
                        default: begin
                            // unknown code: acknowledge, leave accumulator
                            next_q.done = 1'b1;
                        end
                    endcase
                end
            end
            GSM_ST_RUN: begin
                if (rd_fire) begin
                    next_q.rd_addr = q.rd_addr + GSM_ADDR_W'(1);
                    next_q.left_rd = q.left_rd - GSM_CNT_W'(1);
                    next_q.pending = 1'b1;
                end
                if (push) begin
                    next_q.wr_addr = q.wr_addr + GSM_ADDR_W'(1);
                    next_q.pending = 1'b0;
                end
                if (pop) begin
                    next_q.left_wr = q.left_wr - GSM_CNT_W'(1);
                end
                if (q.left_wr == '0) begin
                    next_q.done = 1'b1;
                    next_q.state = GSM_ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= Q_RESET;
        end else begin
            q <= next_q;
        end
    end
endmodule
`default_nettype wire

// *** verif/gsm_exec_unit_assertions.sv ***
/*
 * gsm_chk: port-level properties of the gray / shuffle / copy unit.
 * Assumes one clock domain and is attached by the bind at the foot.
 */
`timescale 1ns/1ps
`default_nettype none
module gsm_chk import gsm_pkg::*; (
    // clock, reset, command
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_ready_o,
    input wire gsm_pkg::gsm_op_t cmd_op_i,
    input wire logic [31:0] acc_i,
    input wire logic [31:0] stack1_i,
    // results and memory ports
    input wire logic done_o,
    input wire logic [31:0] acc_o,
    input wire logic rd_valid_o,
    input wire logic rd_ready_i,
    input wire logic rd_space_o,
    input wire logic [16:0] rd_addr_o,
    input wire logic wr_valid_o,
    input wire logic wr_ready_i,
    input wire logic wr_space_o,
    input wire logic [16:0] wr_addr_o,
    input wire logic [15:0] wr_data_o
);
    gsm_op_t cur_op;
    logic take;
    assign take = cmd_valid_i && cmd_ready_o;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur_op <= GSM_OP_GRAY;
        end else if (take) begin
            cur_op <= cmd_op_i;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence take_s(gsm_op_t o);
        take && cmd_op_i == o;
    endsequence
    gray_done_a: assert property (take_s(GSM_OP_GRAY) |=> done_o)
        else $error("gray result late");
    gray_upper_a: assert property (take_s(GSM_OP_GRAY) |=>
        acc_o[31:10] == 22'h0) else $error("gray upper bits set");
    gray_zero_a: assert property (take_s(GSM_OP_GRAY) ##0
        acc_i[15:0] == 16'h0 |=> acc_o == 32'h0) else $error("gray zero");
    shuf_ident_a: assert property (take_s(GSM_OP_SHUFFLE) ##0
        acc_i == 32'h87654321 |=> acc_o == $past(stack1_i))
        else $error("identity shuffle changed digits");
    shuf_void_a: assert property (take_s(GSM_OP_SHUFFLE) ##0
        acc_i == 32'h0 |=> acc_o == 32'h0) else $error("void order");
    move_empty_a: assert property (take_s(GSM_OP_TABLE_MOVE) ##0
        stack1_i[11:0] == 12'h0 |=> !wr_valid_o ##1 done_o)
        else $error("empty move wrong");
    rd_hold_a: assert property (rd_valid_o && !rd_ready_i |=>
        rd_valid_o && $stable(rd_addr_o)) else $error("read dropped");
    wr_hold_a: assert property (wr_valid_o && !wr_ready_i |=>
        wr_valid_o && $stable(wr_addr_o) && $stable(wr_data_o))
        else $error("write dropped");
    move_space_a: assert property (wr_valid_o &&
        cur_op == GSM_OP_TABLE_MOVE |-> wr_space_o == GSM_SPACE_WORD)
        else $error("move left word memory");
    copy_space_a: assert property (wr_valid_o &&
        cur_op == GSM_OP_WORD_TO_LABEL |-> wr_space_o == GSM_SPACE_LABEL)
        else $error("label write space");
    read_space_a: assert property (rd_valid_o &&
        cur_op == GSM_OP_LABEL_TO_WORD |-> rd_space_o == GSM_SPACE_LABEL)
        else $error("label read space");
endmodule
bind gsm_exec_unit gsm_chk chk (.clock_i, .rst_n_i, .cmd_valid_i,
    .cmd_ready_o, .cmd_op_i, .acc_i, .stack1_i, .done_o, .acc_o,
    .rd_valid_o, .rd_ready_i, .rd_space_o, .rd_addr_o, .wr_valid_o,
    .wr_ready_i, .wr_space_o, .wr_addr_o, .wr_data_o);
`default_nettype wire

// *** verif/gsm_mem_model.sv ***
/*
 * gsm_mem_model: word memory and label memory behind the unit's ports.
 * Assumes the unit's clock; slow_i paces both ports and delays reads.
 */
`timescale 1ns/1ps
`default_nettype none
module gsm_mem_model (
    // clock, reset, pacing
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    // read port
    input wire logic rd_valid_i,
    output logic rd_ready_o,
    input wire logic rd_space_i,
    input wire logic [16:0] rd_addr_i,
    output logic rd_data_valid_o,
    output logic [15:0] rd_data_o,
    // write port
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    input wire logic wr_space_i,
    input wire logic [16:0] wr_addr_i,
    input wire logic [15:0] wr_data_i
);
    logic [15:0] mem [2][256];
    logic pend, tick, rsp;
    logic [1:0] lat;
    logic [7:0] ra;
    assign rd_ready_o = !pend && (!slow_i || tick);
    assign wr_ready_o = !slow_i || !tick;
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend <= 1'b0;
            tick <= 1'b0;
            rd_data_valid_o <= 1'b0;
            rd_data_o <= 16'h0;
        end else begin
            tick <= !tick;
            rd_data_valid_o <= 1'b0;
            // outside a return the bus keeps changing, back to the last word every other cycle
            rd_data_o <= ~rd_data_o;
            if (rd_valid_i && rd_ready_o) begin
                pend <= 1'b1;
                lat <= slow_i ? 2'h2 : 2'h0;
                rsp <= rd_space_i;
                ra <= rd_addr_i[7:0];
            end else if (pend && lat != 2'h0) begin
                lat <= lat - 2'h1;
            end else if (pend) begin
                pend <= 1'b0;
                rd_data_valid_o <= 1'b1;
                rd_data_o <= mem[rsp][ra];
            end
            if (wr_valid_i && wr_ready_o) begin
                mem[wr_space_i][wr_addr_i[7:0]] <= wr_data_i;
            end
        end
    end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
/*
 * testbench: self-checking run of the unit against a memory model.
 * Assumes the bound checker; the far side is gsm_mem_model.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    error_cnt++; $display("ERROR at %0t got %0h exp %0h", $time, g, e); \
    end end
module testbench;
    import gsm_pkg::*;
    logic clock_i, rst_n_i, slow, cmd_valid_i, cmd_ready_o, done_o;
    gsm_op_t cmd_op_i;
    logic [31:0] acc_i, stack1_i, stack2_i, acc_o;
    logic [16:0] operand_i, rd_addr_o, wr_addr_o;
    logic rd_valid_o, rd_ready_i, rd_space_o, rd_data_valid_i;
    logic wr_valid_o, wr_ready_i, wr_space_o;
    logic [15:0] rd_data_i, wr_data_o;
    int error_cnt = 0;
    int samples_checked = 0;
    gsm_exec_unit DUT (.clock_i, .rst_n_i, .cmd_valid_i, .cmd_ready_o,
        .cmd_op_i, .acc_i, .stack1_i, .stack2_i, .operand_i, .done_o,
        .acc_o, .rd_valid_o, .rd_ready_i, .rd_space_o, .rd_addr_o,
        .rd_data_valid_i, .rd_data_i, .wr_valid_o, .wr_ready_i,
        .wr_space_o, .wr_addr_o, .wr_data_o);
    gsm_mem_model mem (.clock_i, .rst_n_i, .slow_i(slow),
        .rd_valid_i(rd_valid_o), .rd_ready_o(rd_ready_i),
        .rd_space_i(rd_space_o), .rd_addr_i(rd_addr_o),
        .rd_data_valid_o(rd_data_valid_i), .rd_data_o(rd_data_i),
        .wr_valid_i(wr_valid_o), .wr_ready_o(wr_ready_i),
        .wr_space_i(wr_space_o), .wr_addr_i(wr_addr_o),
        .wr_data_i(wr_data_o));
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic run(input gsm_op_t op, input logic [31:0] a, s1, s2,
        input int o, output int n);
        @(posedge clock_i);
        cmd_valid_i <= 1'b1;
        cmd_op_i <= op;
        acc_i <= a;
        stack1_i <= s1;
        stack2_i <= s2;
        operand_i <= 17'(o);
        @(posedge clock_i);
        cmd_valid_i <= 1'b0;
        n = 0;
        @(negedge clock_i);
        while (done_o !== 1'b1 && n < 3000) begin
            @(negedge clock_i);
            n++;
        end
        if (n >= 3000) begin
            error_cnt++;
        end
    endtask
    function automatic logic [31:0] gray_exp(input logic [15:0] g);
        logic [15:0] b;
        int d;
        b[15] = g[15];
        for (int i = 14; i >= 0; i--) b[i] = b[i+1] ^ g[i];
        d = int'(b[9:0]);
        d = (d/1000)*4096 + (d/100%10)*256 + (d/10%10)*16 + d%10;
        return {22'h0, 10'(d)};
    endfunction
    function automatic logic [31:0] shuf_exp(input logic [31:0] s, o);
        logic [31:0] r;
        logic [3:0] p;
        r = 32'h0;
        for (int i = 0; i < 8; i++) begin
            p = o[4*i +: 4];
            if (p >= 4'h1 && p <= 4'h8) r[4*(p-1) +: 4] = s[4*i +: 4];
        end
        return r;
    endfunction
    task automatic t_gray();
        logic [15:0] gv [5] = '{16'h0, 16'h0100, 16'h0200, 16'h01B5, 16'hFFFF};
        int n;
        foreach (gv[i]) begin
            run(GSM_OP_GRAY, {16'hA5C3, gv[i]}, 32'h0, 32'h0, 0, n);
            `CHK(acc_o, gray_exp(gv[i]))
            `CHK(n, 0)
        end
        // 360 and 720 count encoders read offset; the program removes it
        run(GSM_OP_GRAY, 32'h00E8, 32'h0, 32'h0, 0, n);
        `CHK(acc_o - 32'h76, 32'h100)
        run(GSM_OP_GRAY, 32'h01D0, 32'h0, 32'h0, 0, n);
        `CHK(acc_o - 32'h152, 32'h200)
        // an unknown code answers at once and leaves the result standing
        run(gsm_op_t'(3'h5), 32'h0, 32'h0, 32'h0, 0, n);
        `CHK(acc_o, 32'h352)
        `CHK(n, 0)
    endtask
    task automatic t_shuffle();
        logic [31:0] sv [5] = '{32'h12345678, 32'h9ABC1234, 32'h12345678,
            32'hFEDCBA98, 32'h13572468};
        logic [31:0] ov [5] = '{32'h87654321, 32'h12345678, 32'h0F9A1B24,
            32'h11223388, 32'h0};
        int n;
        foreach (sv[i]) begin
            run(GSM_OP_SHUFFLE, ov[i], sv[i], 32'h0, 0, n);
            `CHK(acc_o, shuf_exp(sv[i], ov[i]))
        end
    endtask
    task automatic t_copy(input gsm_op_t op, input int cnt, src, dst, off,
        input logic s);
        int n;
        logic ss, ds;
        logic [15:0] exp_w;
        ss = (op == GSM_OP_LABEL_TO_WORD) ? GSM_SPACE_LABEL : GSM_SPACE_WORD;
        ds = (op == GSM_OP_WORD_TO_LABEL) ? GSM_SPACE_LABEL : GSM_SPACE_WORD;
        for (int i = 0; i < 12; i++) begin
            mem.mem[ss][src + i] = 16'hA000 + 16'(i);
            mem.mem[ds][dst + i] = 16'h5555;
        end
        slow <= s;
        if (op == GSM_OP_TABLE_MOVE) begin
            run(op, 32'(src), 32'(cnt), 32'h0, dst, n);
            if (cnt == 0) `CHK(n, 1)
        end else begin
            run(op, 32'(src), 32'(off), 32'(cnt), dst, n);
        end
        for (int i = 0; i < 12; i++) begin
            exp_w = (i >= off && i < off + cnt) ?
                16'hA000 + 16'(i) : 16'h5555;
            `CHK(mem.mem[ds][dst + i], exp_w)
        end
    endtask
    initial begin
        #500_000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        rst_n_i = 1'b0;
        slow = 1'b0;
        cmd_valid_i = 1'b0;
        cmd_op_i = GSM_OP_GRAY;
        acc_i = 32'h0;
        stack1_i = 32'h0;
        stack2_i = 32'h0;
        operand_i = 17'h0;
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_gray();
        t_shuffle();
        t_copy(GSM_OP_TABLE_MOVE, 5, 16, 64, 0, 1'b1);
        t_copy(GSM_OP_TABLE_MOVE, 0, 16, 96, 0, 1'b0);
        t_copy(GSM_OP_LABEL_TO_WORD, 3, 32, 128, 2, 1'b0);
        t_copy(GSM_OP_WORD_TO_LABEL, 4, 48, 160, 1, 1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
